// [hdl/line_sync.sv]
// Purpose: Two-stage synchroniser with a rising-edge pulse for pin inputs.
// Assumes: Inputs are asynchronous to core_clk_i.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module line_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    // Asynchronous inputs.
    input  wire logic [W-1:0] async_i,
    // Synchronised level and rising-edge pulse.
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o
);

    // All state of the synchroniser.
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } sync_s;

    sync_s r_reg;   // Registered state.
    sync_s r_next;  // Next state.

    // The edge compares the second stage with a third copy, never the first.
    always_comb begin
        r_next      = r_reg;
        r_next.meta = async_i;
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
        r_next.rise = r_reg.sync & ~r_reg.prev;
    end

    // Registers with synchronous reset; lines idle high.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            r_reg <= '{meta: '1, sync: '1, prev: '1, rise: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign level_o = r_reg.sync;
    assign rise_o  = r_reg.rise;

endmodule : line_sync

// [hdl/swm_pkg.sv]
// Purpose: Shared constants for the single-wire master reset and reset-pulse command block.
// Assumes: Core clock of 50 MHz; timing codes are four-bit port settings.
// Notes:   All offsets, codes, positions, defaults and timing figures live here.
package swm_pkg;

    // Command codes seen on the host byte interface.
    localparam logic [7:0] CMD_MASTER_RESET = 8'hf0;
    localparam logic [7:0] CMD_RESET_PULSE  = 8'hb4;

    // Core clock period and the documented worst-case response times.
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACT_MAX_NS    = 1090;
    localparam int ACT_MAX_CYC   = ACT_MAX_NS / CLK_PERIOD_NS;
    localparam int DONE_MAX_NS   = 1635;
    localparam int DONE_MAX_CYC  = DONE_MAX_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_US  = 1000 / CLK_PERIOD_NS;

    // Reset-low time is base plus step times code, in microseconds at standard speed.
    localparam int RSTL_BASE_US = 440;
    localparam int RSTL_STEP_US = 20;
    // Presence sample point, same form.
    localparam int MSP_BASE_US  = 58;
    localparam int MSP_STEP_US  = 2;
    // Short sample point after release, fixed.
    localparam int SI_BASE_US   = 8;
    // Overdrive times are the standard times divided by this figure.
    localparam int OD_DIV       = 10;

    // Port timing setting width and selectors for the six settings.
    localparam int          PORT_W    = 4;
    localparam logic [2:0]  PSEL_RSTL = 3'h0;
    localparam logic [2:0]  PSEL_MSP  = 3'h1;
    localparam logic [2:0]  PSEL_W0L  = 3'h2;
    localparam logic [2:0]  PSEL_W1L  = 3'h3;
    localparam logic [2:0]  PSEL_REC  = 3'h4;
    localparam logic [2:0]  PSEL_WPU  = 3'h5;

    // Power-on default codes of the six port settings.
    localparam logic [3:0] RSTL_DEF = 4'h6;
    localparam logic [3:0] MSP_DEF  = 4'h6;
    localparam logic [3:0] W0L_DEF  = 4'h6;
    localparam logic [3:0] W1L_DEF  = 4'h6;
    localparam logic [3:0] REC_DEF  = 4'h6;
    localparam logic [3:0] WPU_DEF  = 4'h6;

    // Configuration bit positions and their reset value.
    localparam int         CFG_OD    = 0;
    localparam int         CFG_APU   = 1;
    localparam int         CFG_PDN   = 2;
    localparam int         CFG_SPU   = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;

    // Read pointer value that selects the master status register.
    localparam logic [7:0] RD_PTR_STATUS = 8'h00;
    localparam logic [7:0] RD_PTR_RESET  = 8'h00;

    // Line sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b010,
        ST_HIGH = 3'b100
    } seq_state_e;

endpackage : swm_pkg

// [hdl/swm_reset_cmds.sv]
// Purpose: Master-reset and reset-pulse command handling of a single-wire bus master.
// Assumes: Command bytes arrive decoded on the core clock; SCL and the line are raw pins.
// Notes:   Commands execute on the synchronised rising SCL edge of their acknowledge bit.
//
// Function
// - Code F0h, no parameter, is master reset.
// - Master reset returns all control state but the read pointer initial.
// - Master reset aborts line activity within 1.09us.
// - Master reset completes within 1.635us, no busy.
// - Master reset sets reset flag, clears others.
// - Master reset clears the four configuration bits.
// - Master reset restores six port timing defaults.
// - Code B4h drives one reset/presence cycle.
// - Reset pulse while busy is refused, ignored.
// - Reset cycle starts within 1.09us of acknowledge.
// - Reset pulse lasts twice reset-low, busy throughout.
// - Busy flag holds for twice reset-low time.
// - Short and presence sampled at their points.
// - Reset pulse points read pointer at status.
// - Reset pulse uses current timing and configuration.
`timescale 1ns/100ps
module swm_reset_cmds #(
    parameter int TICKS_PER_US = swm_pkg::TICKS_PER_US
) (
    // Clock and reset.
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // Host link pin and decoded command byte.
    input  wire logic       scl_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_code_i,
    output logic            cmd_ack_valid_o,
    output logic            cmd_ack_o,
    // Configuration and port timing writes.
    input  wire logic       cfg_wr_i,
    input  wire logic [3:0] cfg_wdata_i,
    input  wire logic       port_wr_i,
    input  wire logic [2:0] port_sel_i,
    input  wire logic [3:0] port_wdata_i,
    // Results from the bit-level commands.
    input  wire logic       bit_upd_i,
    input  wire logic [2:0] bit_res_i,
    // Single-wire line, open drain.
    input  wire logic       line_i,
    output logic            line_o,
    output logic            line_oe_n_o,
    // Status flags.
    output logic            device_reset_flag_o,
    output logic            line_busy_flag_o,
    output logic            presence_detect_flag_o,
    output logic            short_detect_flag_o,
    output logic            single_bit_result_o,
    output logic            triplet_second_bit_o,
    output logic            branch_dir_o,
    // Configuration bits and port settings as applied.
    output logic [3:0]      cfg_o,
    output logic [3:0]      reset_low_time_o,
    output logic [3:0]      presence_sample_time_o,
    output logic [3:0]      write_zero_low_time_o,
    output logic [3:0]      write_one_low_time_o,
    output logic [3:0]      recovery_time_o,
    output logic [3:0]      weak_pullup_resistance_o,
    // Read pointer for the host link.
    output logic [7:0]      rd_ptr_o
);

    // Whole state of the block in one record.
    typedef struct packed {
        swm_pkg::seq_state_e st;        // Line sequencer state.
        logic                pend_mr;   // Master reset waits for its acknowledge edge.
        logic                pend_rp;   // Reset pulse waits for its acknowledge edge.
        logic [23:0]         cnt;       // Phase counter.
        logic [23:0]         rstl_tk;   // Reset-low length latched at start.
        logic [23:0]         msp_tk;    // Presence sample point latched at start.
        logic [23:0]         si_tk;     // Short sample point latched at start.
        logic                ack_v;     // Acknowledge decision pulse.
        logic                ack;       // Acknowledge decision.
        logic                drv;       // Line driven low.
        logic                rst_f;     // Device-reset flag.
        logic                busy_f;    // Line-busy flag.
        logic                ppd_f;     // Presence flag.
        logic                sd_f;      // Short flag.
        logic [2:0]          bits_f;    // Branch direction, triplet bit, single bit.
        logic [3:0]          cfg;       // Configuration bits.
        logic [3:0]          rstl;      // Reset-low time code.
        logic [3:0]          msp;       // Presence sample code.
        logic [3:0]          w0l;       // Write-zero low code.
        logic [3:0]          w1l;       // Write-one low code.
        logic [3:0]          rec;       // Recovery code.
        logic [3:0]          wpu;       // Weak pullup code.
        logic [7:0]          rd_ptr;    // Read pointer.
    } state_s;

    // Power-on state; a master reset rebuilds most of it.
    localparam state_s RESET_VAL = '{
        st: swm_pkg::ST_IDLE, pend_mr: 1'b0, pend_rp: 1'b0, cnt: 24'h0,
        rstl_tk: 24'h0, msp_tk: 24'h0, si_tk: 24'h0, ack_v: 1'b0, ack: 1'b0,
        drv: 1'b0, rst_f: 1'b1, busy_f: 1'b0, ppd_f: 1'b0, sd_f: 1'b0,
        bits_f: 3'h0, cfg: swm_pkg::CFG_RESET, rstl: swm_pkg::RSTL_DEF,
        msp: swm_pkg::MSP_DEF, w0l: swm_pkg::W0L_DEF, w1l: swm_pkg::W1L_DEF,
        rec: swm_pkg::REC_DEF, wpu: swm_pkg::WPU_DEF, rd_ptr: swm_pkg::RD_PTR_RESET};

    state_s r_reg;   // Registered state.
    state_s r_next;  // Next state.

    logic [1:0] pin_lvl;   // Synchronised line and SCL.
    logic [1:0] pin_rise;  // Rising edges of the same.
    logic       scl_rise;  // Acknowledge clock edge seen.
    logic       line_lvl;  // Line level seen.

    // Converts a timing code to core cycles; overdrive times are a tenth.
    function automatic logic [23:0] to_ticks(input int base_us, input int step_us,
                                             input logic [3:0] code, input logic od,
                                             input int tpu);
        int tenths;
        tenths = (base_us + step_us * int'(code)) * (od ? 1 : swm_pkg::OD_DIV);
        return 24'((tenths * tpu) / swm_pkg::OD_DIV);
    endfunction : to_ticks

    // Both pins pass two flip-flops before any logic looks at them.
    line_sync #(
        .W (2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    ({scl_i, line_i}),
        .level_o    (pin_lvl),
        .rise_o     (pin_rise)
    );

    assign scl_rise = pin_rise[1];
    assign line_lvl = pin_lvl[0];

    // Next-state logic: sequencer, writes, command intake, then execution.
    always_comb begin
        r_next       = r_reg;
        r_next.ack_v = 1'b0;

        // Reset/presence sequencer.
        unique case (r_reg.st)
            swm_pkg::ST_IDLE: begin
                r_next.cnt = 24'h0;
            end
            swm_pkg::ST_LOW: begin
                r_next.cnt = r_reg.cnt + 24'h1;
                if (r_reg.cnt >= r_reg.rstl_tk - 24'h1) begin
                    // End of the low phase: release and time the sample window.
                    r_next.drv = 1'b0;
                    r_next.cnt = 24'h0;
                    r_next.st  = swm_pkg::ST_HIGH;
                end
            end
            swm_pkg::ST_HIGH: begin
                r_next.cnt = r_reg.cnt + 24'h1;
                if (r_reg.cnt == r_reg.si_tk - 24'h1) begin
                    r_next.sd_f = ~line_lvl;
                end
                if (r_reg.cnt == r_reg.msp_tk - 24'h1) begin
                    r_next.ppd_f = ~line_lvl;
                end
                if (r_reg.cnt >= r_reg.rstl_tk - 24'h1) begin
                    // Busy ends exactly two reset-low lengths after it rose.
                    r_next.busy_f = 1'b0;
                    r_next.st     = swm_pkg::ST_IDLE;
                end
            end
        endcase

        // Bit-level results from the sibling commands.
        if (bit_upd_i) begin
            r_next.bits_f = bit_res_i;
        end

        // Configuration write also clears the device-reset flag.
        if (cfg_wr_i) begin
            r_next.cfg   = cfg_wdata_i;
            r_next.rst_f = 1'b0;
        end

        // Port timing write, one setting at a time.
        if (port_wr_i) begin
            unique case (port_sel_i)
                swm_pkg::PSEL_RSTL: r_next.rstl = port_wdata_i;
                swm_pkg::PSEL_MSP:  r_next.msp  = port_wdata_i;
                swm_pkg::PSEL_W0L:  r_next.w0l  = port_wdata_i;
                swm_pkg::PSEL_W1L:  r_next.w1l  = port_wdata_i;
                swm_pkg::PSEL_REC:  r_next.rec  = port_wdata_i;
                swm_pkg::PSEL_WPU:  r_next.wpu  = port_wdata_i;
                default: begin
                    // Unused selectors are ignored.
                end
            endcase
        end

        // Command intake: decide the acknowledge right after the byte.
        if (cmd_valid_i && cmd_code_i == swm_pkg::CMD_MASTER_RESET) begin
            r_next.ack_v   = 1'b1;
            r_next.ack     = 1'b1;
            r_next.pend_mr = 1'b1;
            r_next.pend_rp = 1'b0;
        end else if (cmd_valid_i && cmd_code_i == swm_pkg::CMD_RESET_PULSE) begin
            r_next.ack_v = 1'b1;
            // A busy line refuses the code and drops it untouched.
            if (r_reg.busy_f || r_reg.pend_rp || r_reg.pend_mr) begin
                r_next.ack = 1'b0;
            end else begin
                r_next.ack     = 1'b1;
                r_next.pend_rp = 1'b1;
            end
        end

        // Execution on the acknowledge edge; master reset overrides everything.
        if (scl_rise && r_reg.pend_mr) begin
            r_next        = RESET_VAL;
            r_next.rd_ptr = r_reg.rd_ptr;
        end else if (scl_rise && r_reg.pend_rp) begin
            // Lengths are latched now so later writes cannot bend this pulse.
            r_next.rstl_tk = to_ticks(swm_pkg::RSTL_BASE_US, swm_pkg::RSTL_STEP_US,
                                      r_reg.rstl, r_reg.cfg[swm_pkg::CFG_OD],
                                      TICKS_PER_US);
            r_next.msp_tk  = to_ticks(swm_pkg::MSP_BASE_US, swm_pkg::MSP_STEP_US,
                                      r_reg.msp, r_reg.cfg[swm_pkg::CFG_OD],
                                      TICKS_PER_US);
            r_next.si_tk   = to_ticks(swm_pkg::SI_BASE_US, 0, 4'h0,
                                      r_reg.cfg[swm_pkg::CFG_OD], TICKS_PER_US);
            r_next.pend_rp = 1'b0;
            r_next.st      = swm_pkg::ST_LOW;
            r_next.cnt     = 24'h0;
            r_next.drv     = 1'b1;
            r_next.busy_f  = 1'b1;
            r_next.rd_ptr  = swm_pkg::RD_PTR_STATUS;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            r_reg <= RESET_VAL;
        end else begin
            r_reg <= r_next;
        end
    end

    // Every output is taken from the state register alone; line_o is tied low and line_oe_n_o inverts drv.
    assign cmd_ack_valid_o          = r_reg.ack_v;
    assign cmd_ack_o                = r_reg.ack;
    assign line_o                   = 1'b0 & r_reg.drv;
    assign line_oe_n_o              = ~r_reg.drv;
    assign device_reset_flag_o      = r_reg.rst_f;
    assign line_busy_flag_o         = r_reg.busy_f;
    assign presence_detect_flag_o   = r_reg.ppd_f;
    assign short_detect_flag_o      = r_reg.sd_f;
    assign single_bit_result_o      = r_reg.bits_f[0];
    assign triplet_second_bit_o     = r_reg.bits_f[1];
    assign branch_dir_o             = r_reg.bits_f[2];
    assign cfg_o                    = r_reg.cfg;
    assign reset_low_time_o         = r_reg.rstl;
    assign presence_sample_time_o   = r_reg.msp;
    assign write_zero_low_time_o    = r_reg.w0l;
    assign write_one_low_time_o     = r_reg.w1l;
    assign recovery_time_o          = r_reg.rec;
    assign weak_pullup_resistance_o = r_reg.wpu;
    assign rd_ptr_o                 = r_reg.rd_ptr;

    // Helper: length of the current busy period in cycles.
    logic [24:0] busy_len_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !r_reg.busy_f) begin
            busy_len_reg <= 25'h0;
        end else begin
            busy_len_reg <= busy_len_reg + 25'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Execution steps of the two commands.
    sequence mr_fire_s;
        scl_rise && r_reg.pend_mr;
    endsequence
    sequence rp_fire_s;
        scl_rise && r_reg.pend_rp && !r_reg.pend_mr;
    endsequence

    mr_flags_a: assert property (mr_fire_s |=> device_reset_flag_o && !line_busy_flag_o
        && !presence_detect_flag_o && !short_detect_flag_o && branch_dir_o == 1'b0
        && !single_bit_result_o && !triplet_second_bit_o)
        else $error("Master reset left a status flag wrong.");
    mr_config_a: assert property (mr_fire_s |=> cfg_o == swm_pkg::CFG_RESET)
        else $error("Master reset left configuration set.");
    mr_timing_a: assert property (mr_fire_s |=> reset_low_time_o == swm_pkg::RSTL_DEF
        && presence_sample_time_o == swm_pkg::MSP_DEF && write_zero_low_time_o == swm_pkg::W0L_DEF
        && write_one_low_time_o == swm_pkg::W1L_DEF && recovery_time_o == swm_pkg::REC_DEF
        && weak_pullup_resistance_o == swm_pkg::WPU_DEF)
        else $error("Master reset did not restore timing defaults.");
    mr_abort_a: assert property (mr_fire_s |=> line_oe_n_o ##1 line_oe_n_o)
        else $error("Line still driven after master reset.");
    mr_code_a: assert property (cmd_valid_i && cmd_code_i == swm_pkg::CMD_MASTER_RESET
        |=> cmd_ack_valid_o && cmd_ack_o)
        else $error("Master reset code not acknowledged.");
    busy_nack_a: assert property (cmd_valid_i && cmd_code_i == swm_pkg::CMD_RESET_PULSE
        && line_busy_flag_o |=> cmd_ack_valid_o && !cmd_ack_o && !r_reg.pend_rp)
        else $error("Reset pulse accepted while busy.");
    rp_start_a: assert property (rp_fire_s |=> !line_oe_n_o && line_busy_flag_o
        && rd_ptr_o == swm_pkg::RD_PTR_STATUS)
        else $error("Reset pulse did not start on the acknowledge edge.");
    // A master reset cuts the busy period short on purpose, so that fall is not measured.
    busy_len_a: assert property ($fell(line_busy_flag_o)
        && !$past(scl_rise && r_reg.pend_mr) |-> busy_len_reg == {r_reg.rstl_tk, 1'b0})
        else $error("Busy period is not twice the reset-low time.");
    low_len_a: assert property ($rose(line_oe_n_o) && line_busy_flag_o
        |-> r_reg.st == swm_pkg::ST_HIGH && busy_len_reg == {1'b0, r_reg.rstl_tk})
        else $error("Low phase length differs from reset-low time.");
    sample_win_a: assert property ($changed(short_detect_flag_o) && !$past(bit_upd_i)
        |-> $past(r_reg.st) == swm_pkg::ST_HIGH || $past(scl_rise))
        else $error("Short flag changed outside its sample point.");

endmodule : swm_reset_cmds

// [testbench/swm_line_slave.sv]
// Purpose: Behavioural slave population on the single-wire line.
// Assumes: The bench resolves the line level; a pull here drives it low.
// Notes:   Mode 0 is silent, 1 gives a presence pulse, 2 holds the line low (short).
`timescale 1ns/100ps
module swm_line_slave (
    // Resolved line level and bench controls.
    input  wire logic       line_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       od_i,
    // Request to pull the line low.
    output logic            pull_o
);
    realtime t_fall; // Time at which the line last fell.

    // Answer every long enough low once the master lets go of the line.
    initial begin
        pull_o = 1'b0;
        forever begin
            @(negedge line_i);
            t_fall = $realtime;
            @(posedge line_i);
            if ($realtime - t_fall > (od_i ? 2000 : 20000)) begin
                // Presence starts after the short sample point so it never reads as a short.
                if (mode_i == 2'h1) #(od_i ? 200 : 2000) pull_o = 1'b1;
                if (mode_i == 2'h2) #(od_i ? 20 : 100) pull_o = 1'b1;
                #(od_i ? 1000 : 10000) pull_o = 1'b0;
            end
        end
    end
endmodule : swm_line_slave

// [testbench/test_swm_reset_cmds.sv]
// Purpose: Self-checking bench for the master-reset and reset-pulse commands.
// Assumes: Ticks per microsecond shortened to 5; SCL stands high between acknowledges.
// Notes:   Table rows run plain pulses; an aborted pulse and reset follow by hand.
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_swm_reset_cmds;
    localparam int TPU = 5; // Shortened tick rate keeps the run brief.
    typedef struct packed {logic [3:0] code; logic od; logic [1:0] m; logic ep; logic es;} row_s;
    logic clk = 0, rst = 1, scl = 1, cv = 0, cfw = 0, pw = 0, bu = 0, sod = 0, pull;
    logic [7:0] cc = 0;
    logic [3:0] cfd = 0, pd = 0;
    logic [2:0] ps = 0, br = 0;
    logic [1:0] mode = 0;
    logic ackv, ack, lo, oe_n, rf, busy, pp, sd, sb, ts, dir;
    logic [3:0] cfg, t0c, t1c, t2c, t3c, t4c, t5c;
    logic [7:0] rdp;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    realtime t0, t1;
    wire line_w = ~((~oe_n & ~lo) | pull); // Pulled up unless someone drives low.
    wire [6:0] flags = {rf, busy, pp, sd, sb, ts, dir};
    wire [23:0] ports = {t0c, t1c, t2c, t3c, t4c, t5c};
    row_s rows [4] = '{'{4'h0, 1'b0, 2'h1, 1'b1, 1'b0}, '{4'h6, 1'b0, 2'h0, 1'b0, 1'b0},
                       '{4'hf, 1'b0, 2'h2, 1'b1, 1'b1}, '{4'h6, 1'b1, 2'h1, 1'b1, 1'b0}};
    always #10 clk = ~clk;
    swm_reset_cmds #(.TICKS_PER_US(TPU)) uut (.core_clk_i(clk), .sys_rst_i(rst), .scl_i(scl),
        .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_ack_valid_o(ackv), .cmd_ack_o(ack),
        .cfg_wr_i(cfw), .cfg_wdata_i(cfd), .port_wr_i(pw), .port_sel_i(ps), .port_wdata_i(pd),
        .bit_upd_i(bu), .bit_res_i(br), .line_i(line_w), .line_o(lo), .line_oe_n_o(oe_n),
        .device_reset_flag_o(rf), .line_busy_flag_o(busy), .presence_detect_flag_o(pp),
        .short_detect_flag_o(sd), .single_bit_result_o(sb), .triplet_second_bit_o(ts),
        .branch_dir_o(dir), .cfg_o(cfg), .reset_low_time_o(t0c), .presence_sample_time_o(t1c),
        .write_zero_low_time_o(t2c), .write_one_low_time_o(t3c), .recovery_time_o(t4c),
        .weak_pullup_resistance_o(t5c), .rd_ptr_o(rdp));
    swm_line_slave slave (.line_i(line_w), .mode_i(mode), .od_i(sod), .pull_o(pull));

    // Print the counts and the verdict, then stop.
    task finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Send one command byte and look for its acknowledge decision.
    task cmd(input logic [7:0] c, input logic ea);
        logic seen;
        @(negedge clk) cv = 1'b1;
        cc = c;
        @(negedge clk) cv = 1'b0;
        seen = ackv;
        repeat (2) @(negedge clk) seen |= ackv;
        `CHK("ack_valid", 1'b1, seen)
        `CHK("ack", ea, ack)
    endtask : cmd

    // One SCL low-high period; the rising edge executes the command.
    task scl_ack;
        scl = 1'b0;
        #80 scl = 1'b1;
        t0 = $realtime;
    endtask : scl_ack

    // Wait at falling edges while the line is (or is not) driven low, bounded.
    task wait_oe(input logic v);
        int n;
        n = 0;
        while (oe_n === v && n < 20000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_oe

    // Run one reset pulse and check its timing and sampled results.
    task pulse(input row_s r, input logic wr);
        int rt;
        rt = (swm_pkg::RSTL_BASE_US + swm_pkg::RSTL_STEP_US * r.code) * TPU / (r.od ? 10 : 1);
        mode = r.m;
        sod = r.od;
        if (wr) begin
            @(negedge clk) {cfw, cfd, pw, ps, pd} = {1'b1, 3'h0, r.od, 1'b1, 3'h0, r.code};
            @(negedge clk) {cfw, pw} = 2'b00;
        end
        cmd(swm_pkg::CMD_RESET_PULSE, 1'b1);
        scl_ack;
        wait_oe(1'b1);
        t1 = $realtime;
        `CHK("start", 1'b1, t1 - t0 <= swm_pkg::ACT_MAX_NS)
        `CHK("busy", 1'b1, busy)
        `CHK("rd_ptr", swm_pkg::RD_PTR_STATUS, rdp)
        `CHK("line_o", 1'b0, lo)
        wait_oe(1'b0);
        `CHK("low_len", rt, int'(($realtime - t1) / 20))
        while (busy === 1'b1 && $realtime - t1 < 200000) @(negedge clk);
        `CHK("busy_len", 2 * rt, int'(($realtime - t1) / 20))
        `CHK("cmd_len", 1'b1, $realtime - t0 <= 40 * rt + 1090)
        `CHK("presence", r.ep, pp)
        `CHK("short", r.es, sd)
    endtask : pulse

    // Cut a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            finish_test;
        end
    end

    // Main sequence: reset, table rows, aborted pulse with master reset, follow-up pulse.
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        `CHK("rst_flags", 7'h40, flags)
        `CHK("rst_cfg", swm_pkg::CFG_RESET, cfg)
        `CHK("rst_ports", 24'h666666, ports)
        foreach (rows[i]) pulse(rows[i], 1'b1);
        mode = 2'h0;
        cmd(swm_pkg::CMD_RESET_PULSE, 1'b1);
        scl_ack;
        wait_oe(1'b1);
        repeat (100) @(negedge clk);
        cmd(swm_pkg::CMD_RESET_PULSE, 1'b0);
        @(negedge clk) {cfw, cfd, bu, br} = {1'b1, 4'hf, 1'b1, 3'h7};
        for (int s = 0; s < 6; s++) @(negedge clk) {cfw, bu, pw, ps, pd} = {3'b001, 3'(s), 4'h9};
        @(negedge clk) pw = 1'b0;
        `CHK("set_ports", 24'h999999, ports)
        `CHK("set_cfg", 4'hf, cfg)
        `CHK("set_flags", 7'h37, flags)
        cmd(swm_pkg::CMD_MASTER_RESET, 1'b1);
        scl_ack;
        wait_oe(1'b0);
        `CHK("abort", 1'b1, $realtime - t0 <= swm_pkg::ACT_MAX_NS)
        while ($realtime - t0 < swm_pkg::DONE_MAX_NS - 20) @(negedge clk);
        `CHK("mr_flags", 7'h40, flags)
        `CHK("mr_cfg", 4'h0, cfg)
        `CHK("mr_ports", 24'h666666, ports)
        pulse('{4'h6, 1'b0, 2'h1, 1'b1, 1'b0}, 1'b0);
        finish_test;
    end
endmodule : test_swm_reset_cmds
